// ### dv/ccsp_can_model.sv
module ccsp_can_model (
	input wire logic clk,
	input wire logic [4:0] ireg_addr,
	input wire logic [7:0] ireg_wdata,
	input wire logic ireg_wr,
	input wire logic ireg_rd,
	output logic [7:0] ireg_rdata
);
	timeunit 1ns / 1ps;
	logic [7:0] mem_r [32];
	// Idle bus shows inverted data, so a late sample cannot pass
	assign ireg_rdata = ireg_rd ? mem_r[ireg_addr] : ~mem_r[ireg_addr];
	always_ff @(posedge clk) if (ireg_wr) mem_r[ireg_addr] <= ireg_wdata;
endmodule // ccsp_can_model

// ### dv/ccsp_props.sv
module ccsp_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic ireg_wr,
	input wire logic cmd_wr,
	input wire logic reset_request,
	input wire logic dma_start,
	input wire logic dma_done,
	input wire logic dma_busy
);
	timeunit 1ns / 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_dw; sfr_wr && sfr_addr == 8'hda |-> ireg_wr; endproperty
	a_dw: assert property (p_dw) else $error("dw");
	property p_iw; ireg_wr |-> sfr_wr && sfr_addr == 8'hda; endproperty
	a_iw: assert property (p_iw) else $error("iw");
	property p_cw; sfr_wr && sfr_addr == 8'hd9 |-> cmd_wr; endproperty
	a_cw: assert property (p_cw) else $error("cw");
	property p_cx; cmd_wr |-> sfr_wr && sfr_addr == 8'hd9; endproperty
	a_cx: assert property (p_cx) else $error("cx");
	property p_rv; sfr_rd && sfr_addr == 8'hd9 |=> sfr_rdata[7:5] == 3'h7; endproperty
	a_rv: assert property (p_rv) else $error("rv");
	property p_un; sfr_rd && sfr_addr < 8'hd8 |=> sfr_rdata == 8'h00; endproperty
	a_un: assert property (p_un) else $error("un");
	property p_rq; reset_request |-> !dma_start; endproperty
	a_rq: assert property (p_rq) else $error("rq");
	property p_dm; dma_start |-> sfr_wr && sfr_addr == 8'hdb && sfr_wdata[7]; endproperty
	a_dm: assert property (p_dm) else $error("dm");
	sequence s_dma_go; dma_start; endsequence
	sequence s_dma_end; dma_done && dma_busy && !dma_start; endsequence
	property p_db; s_dma_go |=> dma_busy; endproperty
	a_db: assert property (p_db) else $error("start did not raise busy");
	property p_de; s_dma_end |=> !dma_busy; endproperty
	a_de: assert property (p_de) else $error("done did not end busy");
endmodule // ccsp_props
bind ccsp_sfr_port ccsp_props u_props (.*);

// ### dv/tb_cpu_can_sfr_port.sv
module tb_cpu_can_sfr_port;
	timeunit 1ns / 1ps;
	logic clk = 1'b0, rst, sfr_wr, sfr_rd, sfr_bit_wdata, sfr_bit_wr, sfr_bit_rd, sfr_bit_rdata, sfr_hit, ireg_wr;
	logic ireg_rd, cmd_wr, reset_request, dma_start, dma_done, dma_busy;
	logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, ireg_wdata, ireg_rdata, cmd_data, status_bits;
	logic [7:0] dma_ram_pointer;
	logic [4:0] ireg_addr, irq_flags;
	int errors, compares;
	// Bit 16 set writes, clear reads and expects the low byte
	logic [16:0] st [13] = '{17'h0db64, 17'h1da11, 17'h0db65, 17'h1db04, 17'h0da11,
		17'h1db3f, 17'h1daa5, 17'h0db00, 17'h0d9f5,
		17'h1d9a3, 17'h1d840, 17'h0d89c, 17'h0d000};
	ccsp_sfr_port u_dut (.*);
	ccsp_can_model u_can (.*);
	initial forever #2.5 clk = ~clk;
	task chk(input logic [7:0] s, e);
		compares++;
		errors += int'(s !== e);
		if (s !== e) $display("[ERR] %0t %h %h", $time, s, e);
	endtask
	task acc(input logic w, input logic [7:0] a, d);
		@(posedge clk) #1 {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
		@(posedge clk) chk({7'h0, sfr_hit}, {7'h0, a[7:2] == 6'h36});
		chk(cmd_data & {8{cmd_wr}}, (w && a == 8'hd9) ? d : 8'h00);
		#1 {sfr_wr, sfr_rd} = 2'b00;
		if (!w) chk(sfr_rdata, d);
	endtask
	task complete_run;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Generous margin: the sequence needs well under 100 cycles
	initial begin
		#5000 errors++;
		complete_run;
	end
	initial begin
		{sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_rd, sfr_bit_wdata, reset_request, dma_done} = '0;
		{sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
		{rst, irq_flags, status_bits} = {1'b1, 5'h15, 8'h9c};
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 13; i++) acc(st[i][16], st[i][15:8], st[i][7:0]);
		@(posedge clk) #1 {sfr_bit_addr, sfr_bit_wdata, sfr_bit_wr} = {8'hdf, 2'b11};
		@(posedge clk) #1 sfr_bit_wr = 1'b0;
		chk(dma_ram_pointer, 8'hc0);
		@(posedge clk) #1 {sfr_bit_addr, sfr_bit_rd} = {8'hdc, 1'b1};
		@(posedge clk) #1 sfr_bit_rd = 1'b0;
		chk({7'h0, sfr_bit_rdata}, 8'h01);
		@(posedge clk) #1 {sfr_bit_addr, sfr_bit_rd} = {8'hd9, 1'b1};
		@(posedge clk) #1 sfr_bit_rd = 1'b0;
		chk({7'h0, sfr_bit_rdata}, 8'h00);
		reset_request = 1'b1;
		acc(1'b1, 8'hdb, 8'h8a);
		acc(1'b0, 8'hdb, 8'h0a);
		reset_request = 1'b0;
		acc(1'b1, 8'hdb, 8'h8a);
		chk({7'h0, dma_busy}, 8'h01);
		@(posedge clk) #1 dma_done = 1'b1;
		@(posedge clk) #1 dma_done = 1'b0;
		chk({7'h0, dma_busy}, 8'h00);
		acc(1'b0, 8'hdb, 8'h0a);
		complete_run;
	end
endmodule // tb_cpu_can_sfr_port

// ### hdl/ccsp_bit_access.sv
// Bit-addressed read and write on the status port
module ccsp_bit_access
	import ccsp_pkg::*;
(
	input wire logic [7:0] bit_addr,
	input wire logic bit_wdata,
	input wire logic [7:0] cur_byte,
	output logic hit,
	output logic rbit,
	output logic [7:0] new_byte
);
	logic [2:0] idx;
	assign idx = bit_addr[2:0];
	assign hit = (bit_addr & CCSP_BIT_MASK) == CCSP_BIT_BASE;
	assign rbit = cur_byte[idx];
	always_comb begin
		new_byte = cur_byte;
		new_byte[idx] = bit_wdata;
	end
endmodule // ccsp_bit_access

// ### hdl/ccsp_pkg.sv
// Summary of operation
// - Select register at DBH, low five bits address
// - Select register resets to 64H
// - Bit 7 starts and shows DMA
// - Bit 5 enables address auto increment
// - Data port accesses selected internal register
// - Control read returns five interrupt flags
// - Control read bits 7..5 read one
// - Control write drives CAN command register
// - Status read returns eight status bits
// - Status write stores DMA RAM pointer
// - Status port bit-addressable at DFH..D8H
// - Auto increment after each data access
// - DMA bit cleared when transfer completes
// - No DMA start while reset request high
package ccsp_pkg;
	localparam logic [7:0] CCSP_ADDR_STATUS = 8'hd8;
	localparam logic [7:0] CCSP_ADDR_CONTROL = 8'hd9;
	localparam logic [7:0] CCSP_ADDR_DATA = 8'hda;
	localparam logic [7:0] CCSP_ADDR_SELECT = 8'hdb;
	localparam logic [7:0] CCSP_BIT_BASE = 8'hd8;
	localparam logic [7:0] CCSP_BIT_MASK = 8'hf8;
	localparam logic [7:0] CCSP_SELECT_RESET = 8'h64;
	localparam int CCSP_DMA_BIT = 7;
	localparam int CCSP_RSVD_BIT = 6;
	localparam int CCSP_ADDRESS_AUTO_INCREMENT_BIT = 5;
	localparam logic [2:0] CCSP_CTRL_RSVD = 3'h7;
	localparam logic [4:0] CCSP_IREG_LAST = 5'h1f;
	localparam logic [7:0] CCSP_PTR_RESET = 8'h00;
	typedef enum logic [1:0] {
		CCSP_DMA_IDLE = 2'b01,
		CCSP_DMA_RUN = 2'b10
	} ccsp_dma_state_t;
endpackage

// ### hdl/ccsp_sfr_port.sv
module ccsp_sfr_port
	import ccsp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_bit_addr,
	input wire logic sfr_bit_wdata,
	input wire logic sfr_bit_wr,
	input wire logic sfr_bit_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_bit_rdata,
	output logic sfr_hit,
	output logic [4:0] ireg_addr,
	output logic [7:0] ireg_wdata,
	output logic ireg_wr,
	output logic ireg_rd,
	input wire logic [7:0] ireg_rdata,
	input wire logic [4:0] irq_flags,
	output logic [7:0] cmd_data,
	output logic cmd_wr,
	input wire logic [7:0] status_bits,
	input wire logic reset_request,
	output logic [7:0] dma_ram_pointer,
	output logic dma_start,
	input wire logic dma_done,
	output logic dma_busy
);
	logic [7:0] select_r;
	logic [7:0] select_nxt;
	logic [7:0] ptr_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic brdata_r;
	ccsp_dma_state_t dma_r;
	logic sel_acc;
	logic dat_acc;
	logic ctl_acc;
	logic sta_acc;
	logic any_acc;
	logic byte_hit;
	logic bit_hit;
	logic bit_rval;
	logic [7:0] ptr_bitwr;
	logic sel_wr;
	logic dat_step;
	logic dma_set;
	logic dma_ok;
	logic dma_hold;

	// Same comparator for every decoded byte address
	function automatic logic sfr_is(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	assign sel_acc = sfr_is(sfr_addr, CCSP_ADDR_SELECT);
	assign dat_acc = sfr_is(sfr_addr, CCSP_ADDR_DATA);
	assign ctl_acc = sfr_is(sfr_addr, CCSP_ADDR_CONTROL);
	assign sta_acc = sfr_is(sfr_addr, CCSP_ADDR_STATUS);
	assign any_acc = sfr_wr | sfr_rd;
	assign sel_wr = sfr_wr & sel_acc;
	assign dat_step = any_acc & dat_acc & select_r[CCSP_ADDRESS_AUTO_INCREMENT_BIT];

	// A byte address counts as a hit only while a strobe is up
	always_comb begin
		byte_hit = 1'b0;
		if (any_acc) begin
			byte_hit = sel_acc | dat_acc | ctl_acc | sta_acc;
		end
	end
	assign sfr_hit = byte_hit | ((sfr_bit_wr | sfr_bit_rd) & bit_hit);

	// Bit reads see live status
	ccsp_bit_access u_bits_rd (
		.bit_addr(sfr_bit_addr),
		.bit_wdata(sfr_bit_wdata),
		.cur_byte(status_bits),
		.hit(bit_hit),
		.rbit(bit_rval),
		.new_byte()
	);

	// Bit writes edit the pointer; a separate copy keeps a read in the same cycle clean
	ccsp_bit_access u_bits_wr (
		.bit_addr(sfr_bit_addr),
		.bit_wdata(sfr_bit_wdata),
		.cur_byte(ptr_r),
		.hit(),
		.rbit(),
		.new_byte(ptr_bitwr)
	);

	// Strobes pass straight through, so the access ends in the same cycle
	always_comb begin
		ireg_wr = 1'b0;
		ireg_rd = 1'b0;
		cmd_wr = 1'b0;
		if (dat_acc) begin
			ireg_wr = sfr_wr;
			ireg_rd = sfr_rd;
		end
		if (ctl_acc) begin
			cmd_wr = sfr_wr;
		end
	end
	assign ireg_addr = select_r[4:0];
	assign ireg_wdata = sfr_wdata;
	assign cmd_data = sfr_wdata;

	// Start only when the controller is out of reset and the engine is idle or completing in this cycle
	assign dma_busy = dma_r == CCSP_DMA_RUN;
	assign dma_hold = dma_busy & ~dma_done;
	assign dma_ok = ~reset_request & ~dma_hold;
	assign dma_set = sel_wr & sfr_wdata[CCSP_DMA_BIT];
	assign dma_start = dma_set & dma_ok;
	assign dma_ram_pointer = ptr_r;

	// Select register: loaded by a write, stepped by data port accesses
	always_comb begin
		select_nxt = select_r;
		// Completion clears first, so a start in that same cycle still wins
		if (dma_done & dma_busy) begin
			select_nxt[CCSP_DMA_BIT] = 1'b0;
		end
		if (sel_wr) begin
			select_nxt = sfr_wdata;
			select_nxt[CCSP_RSVD_BIT] = 1'b0;
			// Bit 7 mirrors the engine: set by an accepted start, kept while running
			select_nxt[CCSP_DMA_BIT] = dma_start | dma_hold;
		end else if (dat_step) begin
			select_nxt[4:0] = select_r[4:0] + 5'h01;
			// Wrap past the last register ends the auto increment run
			if (select_r[4:0] == CCSP_IREG_LAST) begin
				select_nxt[CCSP_ADDRESS_AUTO_INCREMENT_BIT] = 1'b0;
			end
		end
	end

	// Reserved bit 6 keeps its reset value until the first select write
	always_ff @(posedge clk) begin
		if (rst) begin
			select_r <= CCSP_SELECT_RESET;
		end else begin
			select_r <= select_nxt;
		end
	end

	// Engine state follows the start and done pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			dma_r <= CCSP_DMA_IDLE;
		end else begin
			unique case (dma_r)
				CCSP_DMA_IDLE: begin
					if (dma_start) begin
						dma_r <= CCSP_DMA_RUN;
					end
				end
				CCSP_DMA_RUN: begin
					// A start in the completion cycle chains the next transfer
					if (dma_done & ~dma_start) begin
						dma_r <= CCSP_DMA_IDLE;
					end
				end
				default: begin
					dma_r <= CCSP_DMA_IDLE;
				end
			endcase
		end
	end

	// Pointer is write-only; status reads never disturb it
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_r <= CCSP_PTR_RESET;
		end else if (sfr_wr & sta_acc) begin
			ptr_r <= sfr_wdata;
		end else if (sfr_bit_wr & bit_hit) begin
			ptr_r <= ptr_bitwr;
		end
	end

	// Read mux; unmapped byte addresses read zero
	always_comb begin
		rdata_nxt = 8'h00;
		if (sel_acc) begin
			rdata_nxt = select_r;
		end
		if (dat_acc) begin
			rdata_nxt = ireg_rdata;
		end
		if (ctl_acc) begin
			rdata_nxt = {CCSP_CTRL_RSVD, irq_flags};
		end
		if (sta_acc) begin
			rdata_nxt = status_bits;
		end
	end

	// Registered read data, valid the edge after the strobe and held until the next read
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (sfr_rd) begin
			rdata_r <= rdata_nxt;
		end
	end

	// Bit read result, held until the next bit read
	always_ff @(posedge clk) begin
		if (rst) begin
			brdata_r <= 1'b0;
		end else if (sfr_bit_rd) begin
			brdata_r <= bit_hit & bit_rval;
		end
	end

	assign sfr_rdata = rdata_r;
	assign sfr_bit_rdata = brdata_r;
endmodule // ccsp_sfr_port
